// ### logic/rpt_pkg.sv
// constants for the regulator power-train configuration bank
package rpt_pkg;
   localparam int unsigned ADDR_W = 8;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_MISC_CONTROL = 8'h4C;
   localparam logic [7:0] OFS_ZERO_DETECTOR = 8'h50;
   localparam logic [7:0] OFS_CURRENT_LIMITER = 8'h54;
   localparam logic [7:0] OFS_COMPENSATOR_TRIM = 8'h58;
   localparam logic [7:0] OFS_VOLTAGE_SETTING = 8'h5C;
   // ------------------------------------------------------------
   // writable bit masks and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] MASK_MISC = 32'h377F_FF27;
   localparam logic [31:0] RST_MISC = 32'h0310_7706;
   localparam logic [31:0] MASK_ZDET = 32'h0000_0370;
   localparam logic [31:0] RST_ZDET = 32'h0000_0150;
   localparam logic [31:0] MASK_CLIM = 32'h0000_2300;
   localparam logic [31:0] RST_CLIM = 32'h0000_0100;
   localparam logic [31:0] MASK_COMP = 32'hF730_F1F7;
   localparam logic [31:0] RST_COMP = 32'h5720_4077;
   localparam logic [31:0] MASK_VSET = 32'h0000_7F02;
   localparam logic [31:0] RST_VSET = 32'h0000_7100;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned POS_BIAS = 28;
   localparam int unsigned POS_NOISE_LIMIT = 24;
   localparam int unsigned POS_POWER_LIMIT = 20;
   localparam int unsigned POS_BYP_LEVEL = 16;
   localparam int unsigned POS_NMOS_CNT = 12;
   localparam int unsigned POS_PMOS_CNT = 8;
   localparam int unsigned POS_APPLY_NOW = 5;
   localparam int unsigned POS_HS_THRESH = 2;
   localparam int unsigned POS_HYST_DIS = 1;
   localparam int unsigned POS_FORCE_CONT = 0;
   localparam int unsigned POS_ZDET_BLANK = 8;
   localparam int unsigned POS_REV_THRESH = 4;
   localparam int unsigned POS_BYP_EN = 13;
   localparam int unsigned POS_CLIM_BLANK = 8;
   localparam int unsigned POS_C3 = 28;
   localparam int unsigned POS_C2 = 24;
   localparam int unsigned POS_C1 = 20;
   localparam int unsigned POS_R3 = 12;
   localparam int unsigned POS_R2 = 4;
   localparam int unsigned POS_R1 = 0;
   localparam int unsigned POS_VREF = 8;
   localparam int unsigned POS_ATTEN = 1;
   // ------------------------------------------------------------
   // regulator modes and lock
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_BYPASS = 2'h0;
   localparam logic [1:0] MODE_LOW_NOISE = 2'h1;
   localparam logic [1:0] MODE_LOW_POWER = 2'h2;
   localparam logic [15:0] UNLOCK_KEY = 16'hADE8;
endpackage

// ### logic/rpt_field_reg.sv
// one masked configuration register with reset value and hardware update
`timescale 1ns/1ps
module rpt_field_reg #(
   parameter logic [31:0] MASK = 32'h0,
   parameter logic [31:0] RESET_VALUE = 32'h0
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic wr_i,
   input wire logic [31:0] wdata_i,
   input wire logic hw_wr_i,
   input wire logic [31:0] hw_mask_i,
   input wire logic [31:0] hw_data_i,
   output logic [31:0] value_o
);
   logic [31:0] value;
   logic [31:0] next_value;

   always_comb begin
      next_value = value;
      if (wr_i) begin
         next_value = wdata_i & MASK;
      end
      if (hw_wr_i) begin
         next_value = (next_value & ~hw_mask_i) | (hw_data_i & hw_mask_i & MASK);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         value <= RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end

   assign value_o = value;
endmodule

// ### logic/rpt_config_bank.sv
// register bank that configures the switching regulator power train
// How it works
// (R1) two-bit low-power comparator bias select, reset zero, codes rise with load
// (R2) enabled pmos switches equal programmed count plus one, field resets to seven
// (R3) apply-now bit lets forced conduction change while running, else set before enable
// (R4) forced conduction in low noise: zero-crossing detect, continuous, threshold ignored
// (R5) low power mode always uses zero-crossing detection
// (R6) high-side threshold and hysteresis disable reset to one, keep them one
// (R7) bypass limit enable caps input current in bypass mode, resets zero
// (R8) software clears bypass limit once supply reaches main voltage
// (R9) limiter blank delay resets to one, software leaves it alone
// (R10) compensator cap3 trim is four bits at top, reset five
// (R11) compensator res2 trim is five bits at 8:4, reset seven
// (R12) reference trim seven bits reset 0x71, hardware may update it
// (R13) reference trim with attenuation sets low noise output
// (R14) software writes zero to reserved bits
// (R15) fields reset on power-on, pin and brownout resets
// (R16) attenuation resets zero: zero is one third, one is one sixth
// (R17) bank ignores bus writes while lock_engaged_i is set; the lock input comes from outside the bank
// (R18) reserved bits read as zero
`timescale 1ns/1ps
module rpt_config_bank
   import rpt_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic lock_engaged_i,
   input wire logic [1:0] regulator_mode_i,
   input wire logic regulator_running_i,
   input wire logic vref_update_i,
   input wire logic [6:0] vref_update_value_i,
   output logic [1:0] lp_comparator_bias_select_o,
   output logic [2:0] low_noise_current_limit_level_o,
   output logic [2:0] low_power_current_limit_level_o,
   output logic [3:0] bypass_current_limit_level_o,
   output logic [4:0] nmos_switches_enabled_o,
   output logic [4:0] pmos_switches_enabled_o,
   output logic continuous_conduction_o,
   output logic zero_crossing_detect_o,
   output logic [2:0] reverse_current_threshold_o,
   output logic comparator_high_side_threshold_o,
   output logic state_machine_hysteresis_disable_o,
   output logic [1:0] zero_detector_blank_delay_o,
   output logic bypass_current_limit_active_o,
   output logic [1:0] limiter_blank_delay_o,
   output logic [3:0] compensator_cap3_trim_o,
   output logic [2:0] compensator_cap2_trim_o,
   output logic [1:0] compensator_cap1_trim_o,
   output logic [3:0] compensator_res3_trim_o,
   output logic [4:0] compensator_res2_trim_o,
   output logic [2:0] compensator_res1_trim_o,
   output logic [6:0] low_noise_reference_trim_o,
   output logic low_noise_feedback_attenuation_o
);
   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   localparam int unsigned NREG = 5;
   localparam logic [31:0] MASKS [NREG] = '{MASK_MISC, MASK_ZDET, MASK_CLIM, MASK_COMP,
      MASK_VSET};
   localparam logic [31:0] RSTS [NREG] = '{RST_MISC, RST_ZDET, RST_CLIM, RST_COMP, RST_VSET};

   function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
      if (a == OFS_MISC_CONTROL) begin
         reg_index = 3'h0;
      end else if (a == OFS_ZERO_DETECTOR) begin
         reg_index = 3'h1;
      end else if (a == OFS_CURRENT_LIMITER) begin
         reg_index = 3'h2;
      end else if (a == OFS_COMPENSATOR_TRIM) begin
         reg_index = 3'h3;
      end else if (a == OFS_VOLTAGE_SETTING) begin
         reg_index = 3'h4;
      end else begin
         reg_index = 3'h7;
      end
   endfunction

   logic [31:0] value [NREG];
   logic [2:0] wr_index;

   always_comb begin
      wr_index = reg_index(addr_i);
   end

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         localparam logic [2:0] IDX = 3'(gi);
         logic reg_wr;
         logic hw_wr;
         assign reg_wr = wr_i && !lock_engaged_i && (wr_index == IDX); // R17
         assign hw_wr = (IDX == 3'h4) && vref_update_i; // R12
         rpt_field_reg #(
            .MASK(MASKS[gi]), // R18
            .RESET_VALUE(RSTS[gi]) // R15
         ) u_reg (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .wr_i(reg_wr),
            .wdata_i(wdata_i),
            .hw_wr_i(hw_wr),
            .hw_mask_i(32'h0000_7F00),
            .hw_data_i({17'h0, vref_update_value_i, 8'h0}),
            .value_o(value[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // forced conduction taken at enable unless apply-now is set
   // ------------------------------------------------------------
   logic forced_active;
   logic next_forced_active;
   logic running_q;
   logic next_running_q;

   always_comb begin
      next_running_q = regulator_running_i;
      next_forced_active = forced_active;
      if (!regulator_running_i || !running_q || value[0][POS_APPLY_NOW]) begin
         next_forced_active = value[0][POS_FORCE_CONT]; // R3
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         forced_active <= 1'b0;
         running_q <= 1'b0;
      end else begin
         forced_active <= next_forced_active;
         running_q <= next_running_q;
      end
   end

   // ------------------------------------------------------------
   // output and read data registers
   // ------------------------------------------------------------
   logic [31:0] next_rdata;
   logic next_cont;
   logic next_zcd;
   logic [2:0] next_rev;
   logic next_byp_active;
   logic [2:0] rd_index;

   always_comb begin
      rd_index = reg_index(addr_i);
      next_rdata = 32'h0;
      if (rd_i && rd_index != 3'h7) begin
         next_rdata = value[rd_index]; // R18
      end
      next_cont = (regulator_mode_i == MODE_LOW_NOISE) && forced_active; // R4
      next_zcd = (regulator_mode_i == MODE_LOW_POWER) || next_cont; // R5
      next_rev = next_cont ? 3'h0 : value[1][POS_REV_THRESH +: 3]; // R4
      next_byp_active = (regulator_mode_i == MODE_BYPASS) && value[2][POS_BYP_EN]; // R7
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h0;
         lp_comparator_bias_select_o <= 2'h0;
         low_noise_current_limit_level_o <= 3'h0;
         low_power_current_limit_level_o <= 3'h0;
         bypass_current_limit_level_o <= 4'h0;
         nmos_switches_enabled_o <= 5'h0;
         pmos_switches_enabled_o <= 5'h0;
         continuous_conduction_o <= 1'b0;
         zero_crossing_detect_o <= 1'b0;
         reverse_current_threshold_o <= 3'h0;
         comparator_high_side_threshold_o <= 1'b0;
         state_machine_hysteresis_disable_o <= 1'b0;
         zero_detector_blank_delay_o <= 2'h0;
         bypass_current_limit_active_o <= 1'b0;
         limiter_blank_delay_o <= 2'h0;
         compensator_cap3_trim_o <= 4'h0;
         compensator_cap2_trim_o <= 3'h0;
         compensator_cap1_trim_o <= 2'h0;
         compensator_res3_trim_o <= 4'h0;
         compensator_res2_trim_o <= 5'h0;
         compensator_res1_trim_o <= 3'h0;
         low_noise_reference_trim_o <= 7'h0;
         low_noise_feedback_attenuation_o <= 1'b0;
      end else begin
         rdata_o <= next_rdata;
         lp_comparator_bias_select_o <= value[0][POS_BIAS +: 2]; // R1
         low_noise_current_limit_level_o <= value[0][POS_NOISE_LIMIT +: 3];
         low_power_current_limit_level_o <= value[0][POS_POWER_LIMIT +: 3];
         bypass_current_limit_level_o <= value[0][POS_BYP_LEVEL +: 4];
         nmos_switches_enabled_o <= {1'b0, value[0][POS_NMOS_CNT +: 4]} + 5'h1;
         pmos_switches_enabled_o <= {1'b0, value[0][POS_PMOS_CNT +: 4]} + 5'h1; // R2
         continuous_conduction_o <= next_cont;
         zero_crossing_detect_o <= next_zcd;
         reverse_current_threshold_o <= next_rev;
         comparator_high_side_threshold_o <= value[0][POS_HS_THRESH]; // R6
         state_machine_hysteresis_disable_o <= value[0][POS_HYST_DIS]; // R6
         zero_detector_blank_delay_o <= value[1][POS_ZDET_BLANK +: 2];
         bypass_current_limit_active_o <= next_byp_active;
         limiter_blank_delay_o <= value[2][POS_CLIM_BLANK +: 2]; // R9
         compensator_cap3_trim_o <= value[3][POS_C3 +: 4]; // R10
         compensator_cap2_trim_o <= value[3][POS_C2 +: 3];
         compensator_cap1_trim_o <= value[3][POS_C1 +: 2];
         compensator_res3_trim_o <= value[3][POS_R3 +: 4];
         compensator_res2_trim_o <= value[3][POS_R2 +: 5]; // R11
         compensator_res1_trim_o <= value[3][POS_R1 +: 3];
         low_noise_reference_trim_o <= value[4][POS_VREF +: 7]; // R13
         low_noise_feedback_attenuation_o <= value[4][POS_ATTEN]; // R16
      end
   end
endmodule

// ### sim/rpt_config_bank_monitor.sv
// assertion checker for the regulator configuration bank ports
`timescale 1ns/1ps
module rpt_config_bank_monitor
   import rpt_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic lock_engaged_i,
   input wire logic vref_update_i,
   input wire logic [1:0] regulator_mode_i,
   input wire logic [31:0] rdata_o,
   input wire logic [1:0] lp_comparator_bias_select_o,
   input wire logic [4:0] pmos_switches_enabled_o,
   input wire logic continuous_conduction_o,
   input wire logic zero_crossing_detect_o,
   input wire logic [2:0] reverse_current_threshold_o,
   input wire logic bypass_current_limit_active_o,
   input wire logic [3:0] compensator_cap3_trim_o,
   input wire logic [4:0] compensator_res2_trim_o,
   input wire logic [6:0] low_noise_reference_trim_o
);
   // ----
   // port relations
   // ----
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not zero after idle cycle");
   misc_fields_a: assert property (rd_i && addr_i == OFS_MISC_CONTROL |=>
      pmos_switches_enabled_o == {1'b0, rdata_o[11:8]} + 5'h01 &&
      lp_comparator_bias_select_o == rdata_o[29:28]) else $error("misc outputs differ");
   bypass_limit_a: assert property (rd_i && addr_i == OFS_CURRENT_LIMITER |=>
      bypass_current_limit_active_o == (rdata_o[13] && $past(regulator_mode_i) == MODE_BYPASS))
      else $error("bypass limit output wrong");
   vset_fields_a: assert property (rd_i && addr_i == OFS_VOLTAGE_SETTING && !vref_update_i |=>
      low_noise_reference_trim_o == rdata_o[14:8] && rdata_o[31:15] == 17'h0)
      else $error("reference trim differs");
   comp_fields_a: assert property (rd_i && addr_i == OFS_COMPENSATOR_TRIM |=>
      compensator_cap3_trim_o == rdata_o[31:28] && compensator_res2_trim_o == rdata_o[8:4] &&
      !rdata_o[27]) else $error("compensator outputs differ");
   locked_write_a: assert property (wr_i && lock_engaged_i ##1 !wr_i |=>
      $stable(compensator_cap3_trim_o) && $stable(compensator_res2_trim_o))
      else $error("locked write changed outputs");
   forced_effect_a: assert property (continuous_conduction_o |-> zero_crossing_detect_o &&
      reverse_current_threshold_o == 3'h0 && $past(regulator_mode_i) == MODE_LOW_NOISE)
      else $error("forced conduction effects missing");
   low_power_zero_a: assert property ($past(nrst_i) &&
      $past(regulator_mode_i) == MODE_LOW_POWER |-> zero_crossing_detect_o)
      else $error("zero crossing off in low power");
endmodule

// ### sim/rpt_config_bank_test.sv
// self-checking bench for the regulator configuration bank
`timescale 1ns/1ps
module rpt_config_bank_test
   import rpt_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} rpt_row_s;
   logic clk_sys_i, nrst_i, wr_i, rd_i, lock_engaged_i, regulator_running_i, vref_update_i;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, q;
   logic [1:0] regulator_mode_i, lp_comparator_bias_select_o, limiter_blank_delay_o;
   logic [6:0] vref_update_value_i, low_noise_reference_trim_o;
   logic [4:0] pmos_switches_enabled_o, compensator_res2_trim_o;
   logic [3:0] compensator_cap3_trim_o;
   logic [2:0] reverse_current_threshold_o;
   logic continuous_conduction_o, zero_crossing_detect_o, comparator_high_side_threshold_o;
   logic state_machine_hysteresis_disable_o, bypass_current_limit_active_o;
   logic low_noise_feedback_attenuation_o;
   logic [2:0] low_noise_current_limit_level_o, low_power_current_limit_level_o;
   logic [2:0] compensator_cap2_trim_o, compensator_res1_trim_o;
   logic [3:0] bypass_current_limit_level_o, compensator_res3_trim_o;
   logic [4:0] nmos_switches_enabled_o;
   logic [1:0] zero_detector_blank_delay_o, compensator_cap1_trim_o;
   int errors = 0;
   int n_tests = 0;
   wire [4:0] cz = {continuous_conduction_o, zero_crossing_detect_o, reverse_current_threshold_o};
   rpt_row_s rows [11] = '{'{OFS_MISC_CONTROL, 1'b0, 32'h0, 32'h0310_7706},
      '{OFS_ZERO_DETECTOR, 1'b0, 32'h0, 32'h0000_0150}, '{OFS_CURRENT_LIMITER, 1'b0, 32'h0,
      32'h0000_0100}, '{OFS_COMPENSATOR_TRIM, 1'b0, 32'h0, 32'h5720_4077},
      '{OFS_VOLTAGE_SETTING, 1'b0, 32'h0, 32'h0000_7100},
      '{OFS_MISC_CONTROL, 1'b1, '1, 32'h377F_FF27}, '{OFS_ZERO_DETECTOR, 1'b1, '1, 32'h370},
      '{OFS_CURRENT_LIMITER, 1'b1, '1, 32'h2300}, '{OFS_COMPENSATOR_TRIM, 1'b1, '1, 32'hF730_F1F7},
      '{OFS_VOLTAGE_SETTING, 1'b1, '1, 32'h7F02}, '{8'h60, 1'b1, '1, 32'h0}};
   rpt_config_bank dut_u (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .lock_engaged_i, .regulator_mode_i, .regulator_running_i, .vref_update_i,
      .vref_update_value_i, .lp_comparator_bias_select_o, .low_noise_current_limit_level_o,
      .low_power_current_limit_level_o, .bypass_current_limit_level_o,
      .nmos_switches_enabled_o, .pmos_switches_enabled_o, .continuous_conduction_o,
      .zero_crossing_detect_o, .reverse_current_threshold_o, .comparator_high_side_threshold_o,
      .state_machine_hysteresis_disable_o, .zero_detector_blank_delay_o,
      .bypass_current_limit_active_o, .limiter_blank_delay_o, .compensator_cap3_trim_o,
      .compensator_cap2_trim_o, .compensator_cap1_trim_o, .compensator_res3_trim_o,
      .compensator_res2_trim_o, .compensator_res1_trim_o, .low_noise_reference_trim_o,
      .low_noise_feedback_attenuation_o);
   // ----
   // bus tasks and report
   // ----
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         $display("ERROR %s expected %h seen %h", nm, ex, got);
         errors++;
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= w;
      rd_i <= !w;
      @(posedge clk_sys_i);
      {wr_i, rd_i} <= 2'b00;
      #1 q = rdata_o;
   endtask
   task automatic settle;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic end_sim;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      errors++;
      end_sim();
   end
   // ----
   // scenarios
   // ----
   initial begin
      {nrst_i, wr_i, rd_i, lock_engaged_i, regulator_running_i, vref_update_i} = '0;
      addr_i = '0;
      wdata_i = '0;
      vref_update_value_i = '0;
      regulator_mode_i = MODE_LOW_NOISE;
      repeat (3) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      settle();
      chk("reset fields", {2'h3, 2'h1, 4'h5, 5'h07, 7'h71, 1'b0, 2'h0, 5'h08, 1'b0},
         {comparator_high_side_threshold_o, state_machine_hysteresis_disable_o,
         limiter_blank_delay_o, compensator_cap3_trim_o, compensator_res2_trim_o,
         low_noise_reference_trim_o, low_noise_feedback_attenuation_o,
         lp_comparator_bias_select_o, pmos_switches_enabled_o, bypass_current_limit_active_o});
      chk("reset levels", {3'h3, 3'h1, 4'h0, 5'h08, 2'h1, 3'h7, 2'h2, 4'h4, 3'h7},
         {low_noise_current_limit_level_o, low_power_current_limit_level_o,
         bypass_current_limit_level_o, nmos_switches_enabled_o, zero_detector_blank_delay_o,
         compensator_cap2_trim_o, compensator_cap1_trim_o, compensator_res3_trim_o,
         compensator_res1_trim_o});
      foreach (rows[i]) begin
         if (rows[i].w) acc(1'b1, rows[i].a, rows[i].d);
         acc(1'b0, rows[i].a, 32'h0);
         chk("register read", rows[i].e, q);
      end
      $display("test register table done");
      lock_engaged_i <= 1'b1;
      acc(1'b1, OFS_COMPENSATOR_TRIM, 32'h0);
      acc(1'b0, OFS_COMPENSATOR_TRIM, 32'h0);
      chk("locked write", 32'hF730_F1F7, q);
      lock_engaged_i <= 1'b0;
      acc(1'b1, OFS_COMPENSATOR_TRIM, 32'h1230_5170);
      settle();
      chk("trim outputs", {4'h1, 5'h17}, {compensator_cap3_trim_o, compensator_res2_trim_o});
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, OFS_MISC_CONTROL, (32'(k) << 28) | (32'(k * 5) << 8) | 32'h6);
         settle();
         chk("bias and pmos", {k[1:0], 5'(k * 5 + 1)}, {lp_comparator_bias_select_o, pmos_switches_enabled_o});
      end
      $display("test lock and fields done");
      acc(1'b1, OFS_MISC_CONTROL, 32'h7);
      repeat (2) settle();
      chk("forced conduction", 5'b11000, cz);
      regulator_running_i <= 1'b1;
      acc(1'b1, OFS_MISC_CONTROL, 32'h6);
      repeat (2) settle();
      chk("held while running", 5'b11000, cz);
      acc(1'b1, OFS_MISC_CONTROL, 32'h26);
      repeat (2) settle();
      chk("apply now", 5'b00111, cz);
      regulator_mode_i <= MODE_LOW_POWER;
      repeat (2) settle();
      chk("low power zero", 5'b01111, cz);
      regulator_mode_i <= MODE_BYPASS;
      repeat (2) settle();
      chk("bypass limit on", 32'h1, 32'(bypass_current_limit_active_o));
      acc(1'b1, OFS_CURRENT_LIMITER, 32'h100);
      settle();
      chk("bypass limit off", 32'h0, 32'(bypass_current_limit_active_o));
      $display("test conduction done");
      vref_update_value_i <= 7'h2A;
      vref_update_i <= 1'b1;
      settle();
      vref_update_i <= 1'b0;
      acc(1'b0, OFS_VOLTAGE_SETTING, 32'h0);
      chk("hardware vref", 32'h2A02, q);
      chk("vref outputs", {7'h2A, 1'b1}, {low_noise_reference_trim_o, low_noise_feedback_attenuation_o});
      nrst_i <= 1'b0;
      repeat (2) settle();
      nrst_i <= 1'b1;
      acc(1'b0, OFS_MISC_CONTROL, 32'h0);
      chk("reset again", 32'h0310_7706, q);
      $display("test reset done");
      end_sim();
   end
endmodule
bind rpt_config_bank rpt_config_bank_monitor mon_u (.clk_sys_i, .nrst_i, .addr_i, .wr_i, .rd_i,
   .lock_engaged_i, .vref_update_i, .regulator_mode_i, .rdata_o, .lp_comparator_bias_select_o,
   .pmos_switches_enabled_o, .continuous_conduction_o, .zero_crossing_detect_o,
   .reverse_current_threshold_o, .bypass_current_limit_active_o, .compensator_cap3_trim_o,
   .compensator_res2_trim_o, .low_noise_reference_trim_o);
